// ===== pci_target_term.sv
// Purpose: Target termination control of a PCI target interface
// Assumes: PCI pins arrive on clock_i, address decode done outside
// Notes:   Control pins drive high one cycle before release (turnaround)
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [R1] Lockout answers memory reads and writes with a target retry.
// [R2] Lockout answers configuration reads and writes with a target retry.
// [R3] A lockout retry leaves the internal data bus undriven.
// [R4] Abort request ends memory transfers, bursts too, with a target abort.
// [R5] Every target abort sets the signaled target abort status bit.
// [R6] During retry, stop stays asserted until the initiator drops frame.
// [R7] Ready low with terminate high on first transfer gives a retry.
// [R8] Ready and terminate together give a disconnect with data.
// [R9] Ready alone completes; wait states are inserted until ready.
// [R10] Abort beats lockout, lockout beats ready/terminate handling.
module pci_target_term
  import pci_term_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire pci_in_t     pci_i,
  input  wire backend_t    backend_i,
  input  wire reg_bus_t    bus_i,
  output logic             devsel_n_o,
  output logic             devsel_n_oe_o,
  output logic             trdy_n_o,
  output logic             trdy_n_oe_o,
  output logic             stop_n_o,
  output logic             stop_n_oe_o,
  output logic [31:0]      internal_addr_data_bus_o,
  output logic             internal_addr_data_bus_oe_o,
  output logic             xfer_o,
  output logic             cfg_cycle_o,
  output logic             target_abort_o,
  output logic [31:0]      reg_rdata_o
);

  typedef struct packed {
    fsm_t        fsm;
    logic        frame_n_d;
    logic [3:0]  cmd;
    logic        is_cfg;
    logic        first;
    logic        devsel_n;
    logic        trdy_n;
    logic        stop_n;
    logic        ctl_oe;
    logic [31:0] internal_addr_data_bus;
    logic        internal_addr_data_bus_oe;
    logic        xfer;
    logic        abort_pulse;
    term_t       last_kind;
  } state_t;

  state_t cur;
  state_t next_cur;
  term_t  kind;
  logic   mem_en;

  function automatic logic cmd_is_mem(input logic [3:0] cmd);
    return cmd == CMD_MEM_READ || cmd == CMD_MEM_WRITE;
  endfunction

  function automatic logic cmd_is_cfg(input logic [3:0] cmd);
    return cmd == CMD_CFG_READ || cmd == CMD_CFG_WRITE;
  endfunction

  term_select u_term_select (
    .backend_i (backend_i),
    .first_i   (cur.first),
    .kind_o    (kind)
  );

  cfg_status_reg u_cfg_status_reg (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .bus_i       (bus_i),
    .abort_set_i (cur.abort_pulse),
    .fsm_i       (cur.fsm),
    .last_kind_i (cur.last_kind),
    .mem_en_o    (mem_en),
    .rdata_o     (reg_rdata_o)
  );

  logic addr_phase;
  logic claim;
  logic xfer_now;
  logic last_xfer;

  always_comb begin
    addr_phase = !pci_i.frame_n && cur.frame_n_d;
    claim = (cmd_is_mem(~pci_i.cbe_n) && pci_i.mem_hit && mem_en)
         || (cmd_is_cfg(~pci_i.cbe_n) && pci_i.idsel);
    // A data phase completes when both ready lines were low at this edge
    xfer_now = !cur.trdy_n && !pci_i.irdy_n;
    last_xfer = xfer_now && pci_i.frame_n;
  end

  always_comb begin
    next_cur = cur;
    next_cur.frame_n_d = pci_i.frame_n;
    next_cur.xfer = 1'b0;
    next_cur.abort_pulse = 1'b0;
    unique case (cur.fsm)
      ST_IDLE: begin
        next_cur.ctl_oe = 1'b0;
        next_cur.internal_addr_data_bus_oe = 1'b0;
        if (addr_phase && claim) begin
          next_cur.fsm = ST_DATA;
          next_cur.cmd = ~pci_i.cbe_n;
          next_cur.is_cfg = cmd_is_cfg(~pci_i.cbe_n);
          next_cur.first = 1'b1;
          next_cur.devsel_n = 1'b0;
          next_cur.trdy_n = 1'b1;
          next_cur.stop_n = 1'b1;
          next_cur.ctl_oe = 1'b1;
          next_cur.internal_addr_data_bus = pci_i.ad;
          next_cur.internal_addr_data_bus_oe = 1'b1;
        end
      end

      ST_DATA: begin
        if (xfer_now) begin
          next_cur.xfer = 1'b1;
          next_cur.first = 1'b0;
          next_cur.internal_addr_data_bus = pci_i.ad;
        end
        if (!cur.stop_n) begin
          // Disconnect with data: hold until the data phase completes
          if (xfer_now) begin
            next_cur.trdy_n = 1'b1;                          // [R8]
            next_cur.fsm = pci_i.frame_n ? ST_TURN : ST_STOP_HOLD;
            if (pci_i.frame_n) begin
              next_cur.devsel_n = 1'b1;
              next_cur.stop_n = 1'b1;
            end
          end
        end else if (!cur.trdy_n && !xfer_now) begin
          next_cur.trdy_n = 1'b0;
        end else if (last_xfer) begin
          next_cur.trdy_n = 1'b1;
          next_cur.devsel_n = 1'b1;
          next_cur.fsm = ST_TURN;
        end else begin
          next_cur.last_kind = kind;
          unique case (kind)
            TERM_ABORT: begin
              next_cur.devsel_n = 1'b1;                      // [R4]
              next_cur.trdy_n = 1'b1;
              next_cur.stop_n = 1'b0;
              next_cur.abort_pulse = 1'b1;                   // [R5]
              next_cur.fsm = ST_STOP_HOLD;
            end
            TERM_LOCKOUT: begin
              next_cur.trdy_n = 1'b1;                        // [R1] [R2]
              next_cur.stop_n = 1'b0;
              next_cur.internal_addr_data_bus_oe = 1'b0;                       // [R3]
              next_cur.fsm = ST_STOP_HOLD;
            end
            TERM_RETRY: begin
              next_cur.trdy_n = 1'b1;                        // [R7]
              next_cur.stop_n = 1'b0;
              next_cur.fsm = ST_STOP_HOLD;
            end
            TERM_DISC: begin
              next_cur.trdy_n = 1'b0;                        // [R8]
              next_cur.stop_n = 1'b0;
            end
            TERM_NORMAL: begin
              next_cur.trdy_n = 1'b0;                        // [R9]
            end
            TERM_WAIT: begin
              next_cur.trdy_n = 1'b1;                        // [R9]
            end
            default: begin
              next_cur.trdy_n = 1'b1;
            end
          endcase
        end
      end

      ST_STOP_HOLD: begin
        // Irdy may stay high for many cycles, stop must not drop early
        if (pci_i.frame_n) begin
          next_cur.stop_n = 1'b1;                            // [R6]
          next_cur.devsel_n = 1'b1;
          next_cur.trdy_n = 1'b1;
          next_cur.fsm = ST_TURN;
        end else begin
          next_cur.stop_n = 1'b0;                            // [R6]
        end
      end

      ST_TURN: begin
        // Drive lines high for one cycle so the release is clean
        next_cur.devsel_n = 1'b1;
        next_cur.trdy_n = 1'b1;
        next_cur.stop_n = 1'b1;
        next_cur.ctl_oe = 1'b0;
        next_cur.internal_addr_data_bus_oe = 1'b0;
        next_cur.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cur <= '{fsm: ST_IDLE, frame_n_d: 1'b1, cmd: 4'h0, is_cfg: 1'b0,
               first: 1'b0, devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1,
               ctl_oe: 1'b0, internal_addr_data_bus: 32'h0000_0000, internal_addr_data_bus_oe: 1'b0,
               xfer: 1'b0, abort_pulse: 1'b0, last_kind: TERM_WAIT};
    end else begin
      cur <= next_cur;
    end
  end

  assign devsel_n_o                  = cur.devsel_n;
  assign devsel_n_oe_o               = cur.ctl_oe;
  assign trdy_n_o                    = cur.trdy_n;
  assign trdy_n_oe_o                 = cur.ctl_oe;
  assign stop_n_o                    = cur.stop_n;
  assign stop_n_oe_o                 = cur.ctl_oe;
  assign internal_addr_data_bus_o    = cur.internal_addr_data_bus;
  assign internal_addr_data_bus_oe_o = cur.internal_addr_data_bus_oe;
  assign xfer_o                      = cur.xfer;
  assign cfg_cycle_o                 = cur.is_cfg;
  assign target_abort_o              = cur.abort_pulse;

endmodule
`default_nettype wire

// ===== pci_term_pkg.sv
// Purpose: Shared constants and types for the target termination block
// Assumes: One 200 MHz clock, PCI pins sampled on the same clock
// Notes:   Register offsets are byte addresses on the plain register port
package pci_term_pkg;

  localparam logic [3:0] CMD_MEM_READ  = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ  = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;

  localparam logic [7:0] REG_CMD_STATUS = 8'h04;
  localparam logic [7:0] REG_TERM_INFO  = 8'h40;

  localparam int unsigned CMD_MEM_EN_BIT    = 1;
  localparam int unsigned STS_SIG_ABORT_BIT = 27;
  localparam logic [31:0] CMD_STATUS_RESET  = 32'h0000_0000;
  localparam logic [31:0] CMD_WRITE_MASK    = 32'h0000_0002;

  typedef enum logic [2:0] {
    TERM_WAIT    = 3'h0,
    TERM_NORMAL  = 3'h1,
    TERM_DISC    = 3'h2,
    TERM_RETRY   = 3'h3,
    TERM_LOCKOUT = 3'h4,
    TERM_ABORT   = 3'h5
  } term_t;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'h0,
    ST_DATA      = 2'h1,
    ST_STOP_HOLD = 2'h2,
    ST_TURN      = 2'h3
  } fsm_t;

  typedef struct packed {
    logic ready;
    logic term;
    logic abort_req;
    logic lockout;
  } backend_t;

  typedef struct packed {
    logic        frame_n;
    logic        irdy_n;
    logic        idsel;
    logic        mem_hit;
    logic [3:0]  cbe_n;
    logic [31:0] ad;
  } pci_in_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_bus_t;

endpackage

// ===== term_select.sv
// Purpose: Chooses how the current data phase ends
// Assumes: Back-end inputs are on the PCI clock
// Notes:   Pure combinational priority decode
`timescale 1ns/10ps
`default_nettype none
module term_select
  import pci_term_pkg::*;
(
  input  wire backend_t backend_i,
  input  wire logic     first_i,
  output var  term_t    kind_o
);

  always_comb begin
    if (backend_i.abort_req) begin
      kind_o = TERM_ABORT;                          // [R10] [R4]
    end else if (backend_i.lockout) begin
      kind_o = TERM_LOCKOUT;                        // [R10] [R1] [R2]
    end else if (backend_i.ready && backend_i.term) begin
      kind_o = TERM_DISC;                           // [R8]
    end else if (backend_i.ready) begin
      kind_o = TERM_NORMAL;                         // [R9]
    end else if (backend_i.term) begin
      // After the first transfer this is also reported as TERM_RETRY
      kind_o = first_i ? TERM_RETRY : TERM_RETRY;   // [R7]
    end else begin
      kind_o = TERM_WAIT;                           // [R9]
    end
  end

endmodule
`default_nettype wire

// ===== cfg_status_reg.sv
// Purpose: Command/status register and termination info readback
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Status bit is write-one-to-clear, a new abort beats the clear
`timescale 1ns/10ps
`default_nettype none
module cfg_status_reg
  import pci_term_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire reg_bus_t    bus_i,
  input  wire logic        abort_set_i,
  input  wire fsm_t        fsm_i,
  input  wire term_t       last_kind_i,
  output logic             mem_en_o,
  output logic [31:0]      rdata_o
);

  typedef struct packed {
    logic [31:0] cmd;
    logic        sig_abort;
    logic [31:0] rdata;
  } regs_t;

  regs_t cur;
  regs_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.rdata = 32'h0000_0000;
    if (bus_i.wr && bus_i.addr == REG_CMD_STATUS) begin
      next_cur.cmd = bus_i.wdata & CMD_WRITE_MASK;
      if (bus_i.wdata[STS_SIG_ABORT_BIT]) begin
        next_cur.sig_abort = 1'b0;
      end
    end
    if (abort_set_i) begin
      next_cur.sig_abort = 1'b1;                    // [R5]
    end
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        REG_CMD_STATUS: begin
          next_cur.rdata = cur.cmd;
          next_cur.rdata[STS_SIG_ABORT_BIT] = cur.sig_abort;
        end
        REG_TERM_INFO: next_cur.rdata = {27'h0000000, last_kind_i, fsm_i};
        default:       next_cur.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cur <= '{cmd: CMD_STATUS_RESET, sig_abort: 1'b0, rdata: 32'h0000_0000};
    end else begin
      cur <= next_cur;
    end
  end

  assign mem_en_o = cur.cmd[CMD_MEM_EN_BIT];
  assign rdata_o  = cur.rdata;

endmodule
`default_nettype wire

// ===== term_checker.sv
// Purpose: Assertions on the target termination pins
// Assumes: One clock, synchronous active-low reset
// Notes:   Keeps a shadow of the signaled abort bit for readback checks
`timescale 1ns/10ps
`default_nettype none
module term_checker
  import pci_term_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire pci_in_t     pci_i,
  input wire backend_t    backend_i,
  input wire reg_bus_t    bus_i,
  input wire logic        devsel_n_o,
  input wire logic        devsel_n_oe_o,
  input wire logic        trdy_n_o,
  input wire logic        stop_n_o,
  input wire logic        stop_n_oe_o,
  input wire logic        internal_addr_data_bus_oe_o,
  input wire logic        target_abort_o,
  input wire logic [31:0] reg_rdata_o
);
  logic      flag;
  wire logic clr   = bus_i.wr && bus_i.addr == REG_CMD_STATUS && bus_i.wdata[STS_SIG_ABORT_BIT];
  wire logic plain = !backend_i.abort_req && !backend_i.lockout;
  // A new abort wins over a clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      flag <= 1'b0;
    end else begin
      flag <= target_abort_o | (flag & ~clr);
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_wait;
    !devsel_n_o && devsel_n_oe_o && trdy_n_o && stop_n_o && !pci_i.frame_n;
  endsequence
  sequence s_lock;
    s_wait ##0 (backend_i.lockout && !backend_i.abort_req);
  endsequence
  property p_lock;
    s_lock |=> !stop_n_o && trdy_n_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout not retried");
  property p_hiz;
    s_lock |=> !internal_addr_data_bus_oe_o;
  endproperty
  a_hiz: assert property (p_hiz) else $error("internal bus driven in retry");
  property p_abort;
    s_wait ##0 backend_i.abort_req |=> devsel_n_o && !stop_n_o && target_abort_o;
  endproperty
  a_abort: assert property (p_abort) else $error("no target abort");
  property p_status;
    bus_i.rd && bus_i.addr == REG_CMD_STATUS |=> reg_rdata_o[STS_SIG_ABORT_BIT] == $past(flag);
  endproperty
  a_status: assert property (p_status) else $error("abort status bit wrong");
  property p_hold;
    !stop_n_o && stop_n_oe_o && !pci_i.frame_n |=> !stop_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("stop released early");
  property p_retry;
    s_wait ##0 (plain && backend_i.term && !backend_i.ready) |=> !stop_n_o && trdy_n_o;
  endproperty
  a_retry: assert property (p_retry) else $error("no retry");
  property p_disc;
    s_wait ##0 (plain && backend_i.term && backend_i.ready) |=> !stop_n_o && !trdy_n_o;
  endproperty
  a_disc: assert property (p_disc) else $error("no disconnect with data");
  property p_normal;
    s_wait ##0 (plain && !backend_i.term && backend_i.ready) |=> stop_n_o && !trdy_n_o;
  endproperty
  a_normal: assert property (p_normal) else $error("no normal completion");
endmodule
bind pci_target_term term_checker u_chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .pci_i(pci_i), .backend_i(backend_i), .bus_i(bus_i),
  .devsel_n_o(devsel_n_o), .devsel_n_oe_o(devsel_n_oe_o), .trdy_n_o(trdy_n_o),
  .stop_n_o(stop_n_o), .stop_n_oe_o(stop_n_oe_o), .target_abort_o(target_abort_o),
  .internal_addr_data_bus_oe_o(internal_addr_data_bus_oe_o), .reg_rdata_o(reg_rdata_o)
);
`default_nettype wire

// ===== pci_initiator.sv
// Purpose: Behavioural PCI initiator for the target pins
// Assumes: Pins change by non-blocking assignment after a rising edge
// Notes:   Released lines idle high; ad shows the inverse of its last value
`timescale 1ns/10ps
`default_nettype none
module pci_initiator
  import pci_term_pkg::*;
(
  input  wire logic    clock_i,
  input  wire logic    trdy_n_i,
  input  wire logic    stop_n_i,
  output var  pci_in_t pci_o
);
  initial pci_o = '{1'b1, 1'b1, 1'b0, 1'b0, 4'hf, 32'h0};
  task automatic run(input logic [3:0] cmd, input int words, input int wait_n);
    int  left;
    logic xfer;
    left = words;
    pci_o <= '{1'b0, 1'b1, 1'b1, 1'b1, ~cmd, 32'h1000_0000};
    @(posedge clock_i);
    pci_o.cbe_n <= 4'h0;
    pci_o.ad <= 32'hd000_0000;
    // Frame held with irdy high for the wait span
    repeat (wait_n) @(posedge clock_i);
    pci_o.irdy_n <= 1'b0;
    pci_o.frame_n <= (words == 1);
    repeat (40) begin
      @(posedge clock_i);
      xfer = !trdy_n_i && !pci_o.irdy_n;
      left -= xfer;
      if (pci_o.frame_n && (xfer || !stop_n_i)) break;
      if (!stop_n_i || left == 1) pci_o.frame_n <= 1'b1;
    end
    pci_o <= '{1'b1, 1'b1, 1'b0, 1'b0, ~pci_o.cbe_n, ~pci_o.ad};
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the target termination block
// Assumes: Initiator model drives the PCI pins, bench plays the back end
// Notes:   Pulses are counted once per edge before the edge updates land
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import pci_term_pkg::*;
;
  typedef struct {
    logic [3:0] cmd;
    backend_t   be;
    int         words, wait_n, dly, xfers;
    logic       abort, stop;
  } row_t;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  backend_t    backend_i = '0;
  reg_bus_t    bus_i = '0;
  pci_in_t     pci_i;
  logic        devsel_n_o, devsel_n_oe_o, trdy_n_o, trdy_n_oe_o, stop_n_o, stop_n_oe_o;
  logic        bus_oe, xfer_o, target_abort_o, cfg_o;
  logic [31:0] reg_rdata_o, rd, bus_q;
  int          num_errors = 0, checked = 0, n_xfer = 0, n_abort = 0, n_stop = 0, n_dev = 0;
  row_t        rows [14] = '{
    '{CMD_MEM_WRITE, 4'b1000, 2, 0, 0, 2, 0, 0}, '{CMD_MEM_READ, 4'b1000, 1, 0, 7, 1, 0, 0},
    '{CMD_CFG_READ, 4'b1000, 1, 0, 0, 1, 0, 0}, '{CMD_MEM_WRITE, 4'b1100, 2, 0, 0, 1, 0, 1},
    '{CMD_MEM_READ, 4'b1100, 2, 0, 7, 1, 0, 1}, '{CMD_MEM_WRITE, 4'b0100, 1, 0, 0, 0, 0, 1},
    '{CMD_MEM_READ, 4'b0100, 2, 7, 0, 0, 0, 1}, '{CMD_MEM_WRITE, 4'b0101, 2, 0, 0, 0, 0, 1},
    '{CMD_MEM_READ, 4'b0101, 2, 7, 0, 0, 0, 1}, '{CMD_CFG_WRITE, 4'b0101, 2, 0, 0, 0, 0, 1},
    '{CMD_CFG_READ, 4'b0101, 2, 0, 0, 0, 0, 1}, '{CMD_MEM_WRITE, 4'b0010, 2, 0, 0, 0, 1, 1},
    '{CMD_MEM_READ, 4'b0010, 2, 0, 0, 0, 1, 1}, '{CMD_MEM_WRITE, 4'b0011, 2, 0, 0, 0, 1, 1}};
  always #2.5 clock_i = ~clock_i;
  pci_target_term dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .pci_i(pci_i), .backend_i(backend_i), .bus_i(bus_i),
    .devsel_n_o(devsel_n_o), .devsel_n_oe_o(devsel_n_oe_o), .trdy_n_o(trdy_n_o),
    .trdy_n_oe_o(trdy_n_oe_o), .stop_n_o(stop_n_o), .stop_n_oe_o(stop_n_oe_o),
    .internal_addr_data_bus_o(bus_q), .internal_addr_data_bus_oe_o(bus_oe), .xfer_o(xfer_o),
    .cfg_cycle_o(cfg_o), .target_abort_o(target_abort_o), .reg_rdata_o(reg_rdata_o)
  );
  // Released control lines float high through their pull-ups
  pci_initiator ini (
    .clock_i(clock_i), .trdy_n_i(trdy_n_oe_o ? trdy_n_o : 1'b1),
    .stop_n_i(stop_n_oe_o ? stop_n_o : 1'b1), .pci_o(pci_i)
  );
  always @(posedge clock_i) begin
    n_xfer += (xfer_o === 1'b1);
    n_abort += (target_abort_o === 1'b1);
    n_stop += (stop_n_o === 1'b0 && stop_n_oe_o === 1'b1);
    n_dev += (devsel_n_o === 1'b0);
  end
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Idle cycle after each strobe keeps one assignment per time step
  task automatic bus_op(input logic [7:0] a, input logic [31:0] d, input logic w,
                        output logic [31:0] q);
    bus_i <= '{a, d, w, !w};
    @(posedge clock_i);
    bus_i <= '0;
    // Read data stands only in the cycle after the strobe edge
    #1 q = reg_rdata_o;
    @(posedge clock_i);
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock_i);
    num_errors++;
    complete_run();
  end
  initial begin
    int x, a, s;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    bus_op(REG_CMD_STATUS, 32'h0, 1'b0, rd);
    check_word("status after reset", CMD_STATUS_RESET, rd);
    bus_op(REG_CMD_STATUS, 32'h0000_0002, 1'b1, rd);
    foreach (rows[i]) begin
      x = n_xfer;
      a = n_abort;
      s = n_stop;
      fork
        ini.run(rows[i].cmd, rows[i].words, rows[i].wait_n);
        begin
          repeat (rows[i].dly) @(posedge clock_i);
          backend_i <= rows[i].be;
        end
      join
      backend_i <= '0;
      repeat (3) @(posedge clock_i);
      check_word("transfers", rows[i].xfers, n_xfer - x);
      check_word("aborts", 32'(rows[i].abort), n_abort - a);
      check_word("stop seen", 32'(rows[i].stop), 32'(n_stop != s));
      check_word("cfg cycle", 32'(rows[i].cmd == CMD_CFG_READ || rows[i].cmd == CMD_CFG_WRITE),
                 32'(cfg_o));
      check_word("internal bus", (rows[i].xfers > 0) ? 32'hd000_0000 : 32'h1000_0000,
                 bus_q);
    end
    bus_op(REG_TERM_INFO, 32'h0, 1'b0, rd);
    check_word("last kind", 32'(TERM_ABORT), 32'(rd[4:2]));
    bus_op(REG_CMD_STATUS, 32'h0, 1'b0, rd);
    check_word("status set", 32'h0800_0002, rd);
    bus_op(REG_CMD_STATUS, 32'h0800_0002, 1'b1, rd);
    bus_op(8'h80, 32'hffff_ffff, 1'b1, rd);
    bus_op(8'h80, 32'h0, 1'b0, rd);
    check_word("unmapped", 32'h0, rd);
    bus_op(REG_CMD_STATUS, 32'h0, 1'b0, rd);
    check_word("status cleared", 32'h0000_0002, rd);
    rst_b_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    check_word("stop enable in reset", 32'h0, 32'(stop_n_oe_o));
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    x = n_dev;
    backend_i <= 4'b1000;
    ini.run(CMD_MEM_WRITE, 1, 0);
    check_word("claimed while disabled", 32'h0, n_dev - x);
    complete_run();
  end
endmodule
`default_nettype wire
